//--- shared/exp_bus_pkg.sv
package exp_bus_pkg;
	localparam int ADDR_W     = 28;        // system address width
	localparam int EXP_ADDR_W = 26;        // external address width
	localparam int DATA_W     = 16;        // external data width
	localparam int CNT_W      = 4;         // width of every cycle count
	localparam int NUM_CS     = 5;         // four generic selects plus the fifth
	localparam int NUM_GEN_CS = 4;         // selects with a pin of their own
	localparam logic [2:0] FIFTH_CS = 3'h4;
	localparam logic [3:0] DIV_MIN  = 4'h3;
	localparam logic [3:0] DIV_MAX  = 4'hF;
	localparam logic [2:0] HSIZE_BYTE = 3'h0;
	localparam logic [2:0] HSIZE_HALF = 3'h1;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam int HTRANS_ACTIVE_BIT = 1;  // set for NONSEQ and SEQ
	localparam int FLASH_ALE_BIT     = 9;  // external address bit driving flash ALE
	localparam int FLASH_CLE_BIT     = 10; // external address bit driving flash CLE
	localparam logic [1:0] BEATS_ONE  = 2'h0;
	localparam logic [1:0] BEATS_TWO  = 2'h1;
	localparam logic [1:0] BEATS_FOUR = 2'h3;

	typedef enum logic [7:0] {
		ST_IDLE   = 8'h01,
		ST_DEC    = 8'h02,
		ST_ALE    = 8'h04,
		ST_SETUP  = 8'h08,
		ST_ACTIVE = 8'h10,
		ST_HOLD   = 8'h20,
		ST_ERR    = 8'h40,
		ST_DONE   = 8'h80
	} state_t;
endpackage : exp_bus_pkg

//--- hw/ready_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ready_sync (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic async_i,
	output logic      sync_o
);
	logic meta_q;
	logic sync_q;

	// two-flop synchroniser, first stage read only by the second
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;
endmodule : ready_sync
`default_nettype wire

//--- hw/exp_clk_divider.sv
`timescale 1ns/1ps
`default_nettype none
module exp_clk_divider (
	input  wire logic                           clk_i,
	input  wire logic                           rst_n_i,
	input  wire logic [exp_bus_pkg::CNT_W-1:0]  div_i,
	output logic                                tick_o,
	output logic                                exp_clk_o
);
	logic [exp_bus_pkg::CNT_W-1:0] div_c;
	logic [exp_bus_pkg::CNT_W-1:0] cnt_q;
	logic [exp_bus_pkg::CNT_W-1:0] cnt_d;
	logic                          clk_q;
	logic                          clk_d;

	// clamp divisor into 3..15, count system cycles per external period
	always_comb begin
		div_c = div_i;
		if (div_i < exp_bus_pkg::DIV_MIN) begin
			div_c = exp_bus_pkg::DIV_MIN;
		end
		tick_o = (cnt_q == div_c - 4'h1);
		cnt_d  = tick_o ? 4'h0 : cnt_q + 4'h1;
		clk_d  = (cnt_d < {1'b0, div_c[exp_bus_pkg::CNT_W-1:1]});
	end

	// divider state
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= 4'h0;
			clk_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			clk_q <= clk_d;
		end
	end

	assign exp_clk_o = clk_q;
endmodule : exp_clk_divider
`default_nettype wire

//--- hw/expansion_bus_cycle_engine.sv
`timescale 1ns/1ps
`default_nettype none
module expansion_bus_cycle_engine #(
	parameter int NUM_CS = exp_bus_pkg::NUM_CS
) (
	input  wire logic                                          clk_i,
	input  wire logic                                          rst_n_i,
	// system bus slave
	input  wire logic                                          hsel_i,
	input  wire logic [exp_bus_pkg::ADDR_W-1:0]                haddr_i,
	input  wire logic [1:0]                                    htrans_i,
	input  wire logic                                          hwrite_i,
	input  wire logic [2:0]                                    hsize_i,
	input  wire logic [31:0]                                   hwdata_i,
	input  wire logic                                          hready_i,
	output logic                                               hready_o,
	output logic                                               hresp_o,
	output logic [31:0]                                        hrdata_o,
	// global configuration
	input  wire logic [exp_bus_pkg::CNT_W-1:0]                 clk_div_i,
	input  wire logic                                          clk_out_en_i,
	input  wire logic                                          nand_mode_i,
	input  wire logic                                          fifth_select_enable_i,
	input  wire logic                                          rw_active_high_i,
	input  wire logic                                          cmd_active_high_i,
	// per-select configuration
	input  wire logic [NUM_CS-1:0][exp_bus_pkg::ADDR_W-1:0]    cs_base_i,
	input  wire logic [NUM_CS-1:0][exp_bus_pkg::ADDR_W-1:0]    cs_size_i,
	input  wire logic [NUM_CS-1:0]                             cs_ale_mode_i,
	input  wire logic [NUM_CS-1:0]                             cs_dir_strobe_mode_i,
	input  wire logic [NUM_CS-1:0]                             cs_ready_en_i,
	input  wire logic [NUM_CS-1:0]                             cs_bus16_i,
	input  wire logic [NUM_CS-1:0][exp_bus_pkg::CNT_W-1:0]     cs_setup_i,
	input  wire logic [NUM_CS-1:0][exp_bus_pkg::CNT_W-1:0]     cs_width_i,
	input  wire logic [NUM_CS-1:0][exp_bus_pkg::CNT_W-1:0]     cs_hold_i,
	// external pins
	output logic [exp_bus_pkg::EXP_ADDR_W-1:0]                 exp_addr_o,
	output logic [exp_bus_pkg::DATA_W-1:0]                     exp_data_o,
	output logic [exp_bus_pkg::DATA_W-1:0]                     exp_data_oe_o,
	input  wire logic [exp_bus_pkg::DATA_W-1:0]                exp_data_i,
	output logic [exp_bus_pkg::NUM_GEN_CS-1:0]                 chip_select_n_o,
	output logic                                               fifth_chip_select_n_o,
	output logic                                               read_strobe_n_o,
	output logic                                               write_strobe_n_o,
	output logic                                               ale_o,
	output logic                                               flash_read_strobe_n_o,
	output logic                                               flash_select_pin_n_o,
	output logic                                               flash_addr_latch_o,
	output logic                                               flash_cmd_latch_o,
	output logic [1:0]                                         write_byte_mask_o,
	input  wire logic                                          ready_i,
	output logic                                               exp_clk_o,
	output logic                                               exp_clk_oe_o
);
	exp_bus_pkg::state_t state_q, state_d;
	logic [exp_bus_pkg::ADDR_W-1:0] addr_q, addr_d;
	logic [2:0]                     size_q, size_d;
	logic                           write_q, write_d;
	logic [31:0]                    wdata_q, wdata_d;
	logic [31:0]                    rbuf_q, rbuf_d;
	logic [31:0]                    rdata_q, rdata_d;
	logic [2:0]                     sel_q, sel_d;
	logic [1:0]                     beat_q, beat_d;
	logic [exp_bus_pkg::CNT_W-1:0]  cnt_q, cnt_d;
	logic                           err_q, err_d;
	logic                           rdy_prev_q;
	logic                           rdy_sync;
	logic                           rdy_fall;
	logic                           tick;
	logic                           div_clk;
	logic                           accept;
	logic                           expire;
	logic [NUM_CS-1:0]              hit;
	logic                           any_hit;
	logic [2:0]                     hit_idx;
	logic                           bus16;
	logic                           nand_cycle;
	logic                           ale_eff;
	logic                           strb_eff;
	logic                           busy;
	logic                           cs_act;
	logic                           flash_act;
	logic [1:0]                     last_beat;
	logic [1:0]                     byte_idx;
	logic                           half_idx;
	logic [exp_bus_pkg::EXP_ADDR_W-1:0] eaddr;

	exp_clk_divider u_div (
		.clk_i     (clk_i),
		.rst_n_i   (rst_n_i),
		.div_i     (clk_div_i),
		.tick_o    (tick),
		.exp_clk_o (div_clk)
	);

	ready_sync u_rdy (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.async_i (ready_i),
		.sync_o  (rdy_sync)
	);

	// window decode, one comparator pair per select
	for (genvar i = 0; i < NUM_CS; i++) begin : g_win
		logic en;
		assign en = (i != int'(exp_bus_pkg::FIFTH_CS)) || nand_mode_i
			|| fifth_select_enable_i;
		assign hit[i] = en && (addr_q >= cs_base_i[i])
			&& ((addr_q - cs_base_i[i]) < cs_size_i[i]);
	end

	// lowest-numbered matching select wins
	always_comb begin
		any_hit = 1'b0;
		hit_idx = 3'h0;
		for (int i = NUM_CS - 1; i >= 0; i--) begin
			if (hit[i]) begin
				any_hit = 1'b1;
				hit_idx = 3'(i);
			end
		end
	end

	// effective mode of the latched select
	always_comb begin
		bus16      = cs_bus16_i[sel_q];
		nand_cycle = nand_mode_i && (sel_q == exp_bus_pkg::FIFTH_CS);
		ale_eff    = cs_ale_mode_i[sel_q] && !cs_dir_strobe_mode_i[sel_q]
			&& !nand_cycle;
		strb_eff   = cs_dir_strobe_mode_i[sel_q] && !cs_ale_mode_i[sel_q]
			&& !nand_cycle;
	end

	// beats per access, lane indices and external address
	always_comb begin
		last_beat = exp_bus_pkg::BEATS_ONE;
		if (size_q == exp_bus_pkg::HSIZE_WORD) begin
			last_beat = bus16 ? exp_bus_pkg::BEATS_TWO : exp_bus_pkg::BEATS_FOUR;
		end else if (size_q == exp_bus_pkg::HSIZE_HALF && !bus16) begin
			last_beat = exp_bus_pkg::BEATS_TWO;
		end
		byte_idx = addr_q[1:0];
		half_idx = addr_q[1];
		if (size_q == exp_bus_pkg::HSIZE_WORD) begin
			byte_idx = beat_q;
			half_idx = beat_q[0];
		end else if (size_q == exp_bus_pkg::HSIZE_HALF) begin
			byte_idx = {addr_q[1], beat_q[0]};
		end
		if (bus16) begin
			if (size_q == exp_bus_pkg::HSIZE_WORD) begin
				eaddr = {addr_q[exp_bus_pkg::EXP_ADDR_W:2], beat_q[0]};
			end else begin
				eaddr = addr_q[exp_bus_pkg::EXP_ADDR_W:1];
			end
		end else begin
			case (size_q)
				exp_bus_pkg::HSIZE_WORD: eaddr = {addr_q[exp_bus_pkg::EXP_ADDR_W-1:2], beat_q};
				exp_bus_pkg::HSIZE_HALF: eaddr = {addr_q[exp_bus_pkg::EXP_ADDR_W-1:1], beat_q[0]};
				default:                 eaddr = addr_q[exp_bus_pkg::EXP_ADDR_W-1:0];
			endcase
		end
	end

	assign accept = hsel_i && htrans_i[exp_bus_pkg::HTRANS_ACTIVE_BIT] && hready_i
		&& (state_q == exp_bus_pkg::ST_IDLE || state_q == exp_bus_pkg::ST_DONE);
	assign expire   = tick && (cnt_q == 4'h0);
	assign rdy_fall = rdy_prev_q && !rdy_sync;

	// cycle sequencer next state
	always_comb begin
		state_d = state_q;
		addr_d  = addr_q;
		size_d  = size_q;
		write_d = write_q;
		wdata_d = wdata_q;
		rbuf_d  = rbuf_q;
		rdata_d = rdata_q;
		sel_d   = sel_q;
		beat_d  = beat_q;
		cnt_d   = cnt_q;
		err_d   = err_q;
		if (tick && cnt_q != 4'h0) begin
			cnt_d = cnt_q - 4'h1;
		end
		case (state_q)
			exp_bus_pkg::ST_IDLE, exp_bus_pkg::ST_DONE: begin
				state_d = exp_bus_pkg::ST_IDLE;
				if (accept) begin
					state_d = exp_bus_pkg::ST_DEC;
					addr_d  = haddr_i;
					size_d  = hsize_i;
					write_d = hwrite_i;
					err_d   = 1'b0;
				end
			end
			exp_bus_pkg::ST_DEC: begin
				wdata_d = hwdata_i;
				beat_d  = 2'h0;
				sel_d   = hit_idx;
				cnt_d   = cs_setup_i[hit_idx];
				if (!any_hit) begin
					err_d   = 1'b1;
					state_d = exp_bus_pkg::ST_ERR;
				end else if (cs_ale_mode_i[hit_idx] && !cs_dir_strobe_mode_i[hit_idx]
					&& !(nand_mode_i && hit_idx == exp_bus_pkg::FIFTH_CS)) begin
					state_d = exp_bus_pkg::ST_ALE;
				end else begin
					state_d = exp_bus_pkg::ST_SETUP;
				end
			end
			exp_bus_pkg::ST_ALE: begin
				cnt_d = cs_setup_i[sel_q];
				if (tick) begin
					state_d = exp_bus_pkg::ST_SETUP;
				end
			end
			exp_bus_pkg::ST_SETUP: begin
				if (expire) begin
					state_d = exp_bus_pkg::ST_ACTIVE;
					cnt_d   = cs_width_i[sel_q];
				end
			end
			exp_bus_pkg::ST_ACTIVE: begin
				if (expire || (cs_ready_en_i[sel_q] && rdy_fall)) begin
					state_d = exp_bus_pkg::ST_HOLD;
					cnt_d   = cs_hold_i[sel_q];
					if (cs_ready_en_i[sel_q] && !rdy_fall) begin
						err_d = 1'b1;
					end
					if (!write_q && bus16) begin
						rbuf_d[16*half_idx +: 16] = exp_data_i;
					end else if (!write_q) begin
						rbuf_d[8*byte_idx +: 8] = exp_data_i[7:0];
					end
				end
			end
			exp_bus_pkg::ST_HOLD: begin
				if (expire) begin
					if (beat_q == last_beat) begin
						state_d = err_q ? exp_bus_pkg::ST_ERR : exp_bus_pkg::ST_DONE;
						case (size_q)
							exp_bus_pkg::HSIZE_BYTE: rdata_d = {4{rbuf_q[8*addr_q[1:0] +: 8]}};
							exp_bus_pkg::HSIZE_HALF: rdata_d = {2{rbuf_q[16*addr_q[1] +: 16]}};
							default:                 rdata_d = rbuf_q;
						endcase
					end else begin
						beat_d  = beat_q + 2'h1;
						cnt_d   = cs_setup_i[sel_q];
						state_d = ale_eff ? exp_bus_pkg::ST_ALE : exp_bus_pkg::ST_SETUP;
					end
				end
			end
			exp_bus_pkg::ST_ERR: begin
				state_d = exp_bus_pkg::ST_DONE;
			end
			default: begin
				state_d = exp_bus_pkg::ST_IDLE;
			end
		endcase
	end

	// sequencer registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q    <= exp_bus_pkg::ST_IDLE;
			addr_q     <= '0;
			size_q     <= 3'h0;
			write_q    <= 1'b0;
			wdata_q    <= 32'h0;
			rbuf_q     <= 32'h0;
			rdata_q    <= 32'h0;
			sel_q      <= 3'h0;
			beat_q     <= 2'h0;
			cnt_q      <= 4'h0;
			err_q      <= 1'b0;
			rdy_prev_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			addr_q     <= addr_d;
			size_q     <= size_d;
			write_q    <= write_d;
			wdata_q    <= wdata_d;
			rbuf_q     <= rbuf_d;
			rdata_q    <= rdata_d;
			sel_q      <= sel_d;
			beat_q     <= beat_d;
			cnt_q      <= cnt_d;
			err_q      <= err_d;
			rdy_prev_q <= rdy_sync;
		end
	end

	// system bus answer: stalled until every beat is done
	assign hready_o = (state_q == exp_bus_pkg::ST_IDLE)
		|| (state_q == exp_bus_pkg::ST_DONE);
	assign hresp_o  = (state_q == exp_bus_pkg::ST_ERR)
		|| (state_q == exp_bus_pkg::ST_DONE && err_q);
	assign hrdata_o = rdata_q;

	assign busy   = (state_q == exp_bus_pkg::ST_ALE) || (state_q == exp_bus_pkg::ST_SETUP)
		|| (state_q == exp_bus_pkg::ST_ACTIVE) || (state_q == exp_bus_pkg::ST_HOLD);
	assign cs_act = (state_q == exp_bus_pkg::ST_ACTIVE);
	assign flash_act = cs_act && nand_mode_i
		&& (nand_cycle || sel_q < exp_bus_pkg::FIFTH_CS);

	// external pin drive
	always_comb begin
		exp_addr_o    = busy ? eaddr : '0;
		exp_data_o    = '0;
		exp_data_oe_o = '0;
		if (ale_eff && (state_q == exp_bus_pkg::ST_ALE
			|| (state_q == exp_bus_pkg::ST_SETUP && write_q))) begin
			exp_data_o    = eaddr[exp_bus_pkg::DATA_W-1:0];
			exp_data_oe_o = '1;
		end else if (write_q && busy) begin
			exp_data_o    = bus16 ? wdata_q[16*half_idx +: 16]
				: {8'h00, wdata_q[8*byte_idx +: 8]};
			exp_data_oe_o = '1;
		end
		write_byte_mask_o = 2'h0;
		if (bus16 && size_q == exp_bus_pkg::HSIZE_BYTE && busy) begin
			write_byte_mask_o = addr_q[0] ? 2'h1 : 2'h2;
		end
		for (int i = 0; i < exp_bus_pkg::NUM_GEN_CS; i++) begin
			chip_select_n_o[i] = !(cs_act && sel_q == 3'(i));
		end
		if (nand_mode_i) begin
			fifth_chip_select_n_o = !(flash_act && write_q);
		end else begin
			fifth_chip_select_n_o = !(cs_act && sel_q == exp_bus_pkg::FIFTH_CS);
		end
		flash_read_strobe_n_o = !(flash_act && !write_q);
		flash_select_pin_n_o  = !(busy && nand_cycle);
		flash_addr_latch_o    = busy && nand_cycle && eaddr[exp_bus_pkg::FLASH_ALE_BIT];
		flash_cmd_latch_o     = busy && nand_cycle && eaddr[exp_bus_pkg::FLASH_CLE_BIT];
		ale_o = ale_eff && (state_q == exp_bus_pkg::ST_ALE);
		if (strb_eff) begin
			write_strobe_n_o = rw_active_high_i ? (busy && write_q) : !(busy && write_q);
			read_strobe_n_o  = cmd_active_high_i ? cs_act : !cs_act;
		end else begin
			write_strobe_n_o = !(cs_act && write_q && !nand_cycle);
			read_strobe_n_o  = !(cs_act && !write_q && !nand_cycle);
		end
	end

	assign exp_clk_o    = div_clk && clk_out_en_i;
	assign exp_clk_oe_o = clk_out_en_i;
endmodule : expansion_bus_cycle_engine
`default_nettype wire

//--- test/exp_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module exp_periph_model (
	input  wire logic        clk_i,
	input  wire logic [3:0]  cs_n_i,
	input  wire logic        rd_n_i,
	input  wire logic        wr_n_i,
	input  wire logic [25:0] addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic [1:0]  mask_i,
	input  wire logic [3:0]  dly_i,
	input  wire logic        mute_i,
	output logic      [15:0] rdata_o,
	output logic             ready_o
);
	logic [15:0] mem [0:4095];
	logic [15:0] wd_q, last_q, keep;
	logic [11:0] idx, idx_q;
	logic [3:0]  cnt_q, rc_q;
	logic [1:0]  mk_q;
	logic        act, wr_q, wact_q;
	// empty memory and a known bus pattern at start
	initial begin
		last_q = 16'h0000;
		wr_q = 1'b1;
		wact_q = 1'b0;
		cnt_q = 4'h0;
		rc_q = 4'h0;
		for (int j = 0; j < 4096; j++) mem[j] = 16'h0000;
	end
	// selected device and the word it addresses
	assign act = (cs_n_i != 4'hF);
	assign idx = {!cs_n_i[3] ? 2'h3 : !cs_n_i[2] ? 2'h2 : !cs_n_i[1] ? 2'h1 : 2'h0, addr_i[9:0]};
	assign keep = {{8{mk_q[1]}}, {8{mk_q[0]}}};
	// data only after the strobe has been low a while, a toggling pattern otherwise
	assign rdata_o = (rc_q >= 4'h2) ? mem[idx] : ~last_q;
	// ready drops some cycles into the select unless kept silent
	assign ready_o = !(act && cnt_q >= dly_i && !mute_i);
	// counters, write capture at the strobe's rising edge
	always @(posedge clk_i) begin
		last_q <= rdata_o;
		wr_q <= wr_n_i;
		cnt_q <= act ? cnt_q + {3'h0, cnt_q != 4'hF} : 4'h0;
		rc_q <= (act && !rd_n_i) ? rc_q + {3'h0, rc_q != 4'hF} : 4'h0;
		if (!wr_n_i) begin
			idx_q <= idx;
			wd_q <= wdata_i;
			mk_q <= mask_i;
			wact_q <= act;
		end
		if (wr_n_i && !wr_q && wact_q) mem[idx_q] <= (wd_q & ~keep) | (mem[idx_q] & keep);
	end
endmodule : exp_periph_model
`default_nettype wire

//--- test/expansion_bus_cycle_engine_chk.sv
`timescale 1ns/1ps
`default_nettype none
module expansion_bus_cycle_engine_chk #(
	parameter int NUM_CS = exp_bus_pkg::NUM_CS
) (
	input wire logic              clk_i,
	input wire logic              rst_n_i,
	input wire logic              hready_o,
	input wire logic              hresp_o,
	input wire logic              clk_out_en_i,
	input wire logic              nand_mode_i,
	input wire logic [NUM_CS-1:0] cs_dir_strobe_mode_i,
	input wire logic [15:0]       exp_data_oe_o,
	input wire logic [15:0]       exp_data_o,
	input wire logic [25:0]       exp_addr_o,
	input wire logic [3:0]        chip_select_n_o,
	input wire logic              read_strobe_n_o,
	input wire logic              write_strobe_n_o,
	input wire logic              ale_o,
	input wire logic              flash_read_strobe_n_o,
	input wire logic              flash_select_pin_n_o,
	input wire logic              flash_addr_latch_o,
	input wire logic              flash_cmd_latch_o,
	input wire logic              exp_clk_o,
	input wire logic              exp_clk_oe_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	logic plain;
	// strobe pins keep their read and write meaning
	assign plain = (cs_dir_strobe_mode_i == '0);
	sequence err_seq;
		!hready_o && hresp_o ##1 hready_o && hresp_o;
	endsequence
	a_err_shape: assert property ($rose(hresp_o) |-> err_seq)
		else $error("error reply malformed");
	a_stall_cs: assert property (chip_select_n_o != 4'hF |-> !hready_o)
		else $error("system bus free during select");
	a_read_float: assert property (plain && !read_strobe_n_o |-> exp_data_oe_o == '0)
		else $error("data driven during read");
	a_one_strobe: assert property (plain |-> read_strobe_n_o || write_strobe_n_o)
		else $error("both strobes active");
	a_write_hold: assert property (plain && $rose(write_strobe_n_o) |-> (exp_data_oe_o != '0) [*2])
		else $error("write data dropped early");
	a_ale_addr: assert property (ale_o |-> exp_data_oe_o == '1 &&
		exp_data_o == exp_addr_o[15:0] && chip_select_n_o == 4'hF)
		else $error("latch strobe without address on data");
	a_flash_latch: assert property (!flash_select_pin_n_o |->
		flash_addr_latch_o == exp_addr_o[9] && flash_cmd_latch_o == exp_addr_o[10])
		else $error("flash latch enables off address");
	a_flash_mirror: assert property (nand_mode_i && plain && chip_select_n_o != 4'hF &&
		!read_strobe_n_o |-> !flash_read_strobe_n_o)
		else $error("flash read strobe silent");
	a_clk_gate: assert property (!clk_out_en_i |-> !exp_clk_o && !exp_clk_oe_o)
		else $error("clock out while disabled");
	a_clk_min: assert property ($rose(exp_clk_o) && $past(clk_out_en_i) |=> !$rose(exp_clk_o) [*2])
		else $error("clock period under three");
endmodule : expansion_bus_cycle_engine_chk
bind expansion_bus_cycle_engine expansion_bus_cycle_engine_chk #(.NUM_CS(NUM_CS)) i_chk (.*);
`default_nettype wire

//--- test/expansion_bus_cycle_engine_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, want) begin total_checks++; if ((got) !== (want)) begin fails++; \
	$display("mismatch at %0t: got %h want %h", $time, got, want); end end
module expansion_bus_cycle_engine_bench;
	logic clk_i, rst_n_i, hsel_i, hwrite_i, hready_i, hready_o, hresp_o, ready_i;
	logic clk_out_en_i, nand_mode_i, fifth_select_enable_i, rw_active_high_i, cmd_active_high_i;
	logic fifth_chip_select_n_o, read_strobe_n_o, write_strobe_n_o, ale_o, flash_read_strobe_n_o;
	logic flash_select_pin_n_o, flash_addr_latch_o, flash_cmd_latch_o, exp_clk_o, exp_clk_oe_o;
	logic [27:0] haddr_i, a;
	logic [31:0] hwdata_i, hrdata_o, rd;
	logic [4:0][27:0] cs_base_i, cs_size_i;
	logic [4:0][3:0] cs_setup_i, cs_width_i, cs_hold_i;
	logic [4:0] cs_ale_mode_i, cs_dir_strobe_mode_i, cs_ready_en_i, cs_bus16_i;
	logic [25:0] exp_addr_o;
	logic [15:0] exp_data_o, exp_data_oe_o, exp_data_i, rnd;
	logic [3:0] chip_select_n_o, clk_div_i, dly;
	logic [2:0] hsize_i, sz;
	logic [1:0] htrans_i, write_byte_mask_o, wm;
	logic w, er, mute, ck_q, seen5, seenf, seenr, seena;
	logic [7:0] sh [0:32767];
	int fails, total_checks, rises, i, k, m;

	expansion_bus_cycle_engine i_dut (.*);
	exp_periph_model i_dev (.clk_i(clk_i), .cs_n_i(chip_select_n_o), .rd_n_i(read_strobe_n_o),
		.wr_n_i(write_strobe_n_o), .addr_i(exp_addr_o), .wdata_i(exp_data_o),
		.mask_i(write_byte_mask_o), .dly_i(dly), .mute_i(mute), .rdata_o(exp_data_i),
		.ready_o(ready_i));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// pin watcher: clock rises, strobes seen, last write mask
	always @(posedge clk_i) begin
		ck_q <= exp_clk_o;
		if (exp_clk_o && !ck_q) rises <= rises + 1;
		if (!fifth_chip_select_n_o) seen5 <= 1'b1;
		if (!flash_select_pin_n_o) seenf <= 1'b1;
		if (!flash_read_strobe_n_o) seenr <= 1'b1;
		if (ale_o) seena <= 1'b1;
		if (!write_strobe_n_o) wm <= write_byte_mask_o;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	// read value from the shadow, replicated over the lanes
	function automatic logic [31:0] exp_rd(input logic [27:0] ad, input logic [2:0] s);
		int b;
		b = ad[14:0];
		if (s == exp_bus_pkg::HSIZE_BYTE) return {4{sh[b]}};
		if (s == exp_bus_pkg::HSIZE_HALF) return {2{sh[b + 1], sh[b]}};
		return {sh[b + 3], sh[b + 2], sh[b + 1], sh[b]};
	endfunction : exp_rd

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : give_verdict

	// one system access, shadow update and comparison
	task automatic acc(input logic wr, input logic [27:0] ad, input logic [2:0] s,
		input logic [31:0] wd);
		int n, j;
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		hwrite_i <= wr;
		haddr_i <= ad;
		hsize_i <= s;
		n = 0;
		do begin @(posedge clk_i); n++; end while (hready_o !== 1'b1 && n < 3000);
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= wd;
		do begin @(posedge clk_i); n++; end while (hready_o !== 1'b1 && n < 3000);
		if (n >= 3000) begin
			fails++;
			$display("mismatch at %0t: access timed out", $time);
			give_verdict();
		end
		rd = hrdata_o;
		er = hresp_o;
		if (wr) for (j = 0; j < (1 << s); j++) sh[ad[14:0] + j] = wd[8 * (ad[1:0] + j) +: 8];
		if (wr && ad[14:12] < 3'h4 && !er)
			`CHK(wm, (cs_bus16_i[ad[14:12]] && s == 3'h0) ? {~ad[0], ad[0]} : 2'h0)
		if (!wr && !er) `CHK(rd, exp_rd(ad, s))
	endtask : acc

	initial begin
		rnd = 16'h6180;
		{hsel_i, hwrite_i, haddr_i, htrans_i, hsize_i, hwdata_i} = '0;
		hready_i = 1'b1;
		clk_div_i = 4'h5;
		{clk_out_en_i, nand_mode_i, fifth_select_enable_i} = 3'h6;
		{rw_active_high_i, cmd_active_high_i} = 2'h0;
		for (k = 0; k < 5; k++) begin
			cs_base_i[k] = 28'(k) << 12;
			cs_size_i[k] = 28'h1000;
			cs_setup_i[k] = 4'h1;
			cs_width_i[k] = 4'h3;
			cs_hold_i[k] = 4'h1;
		end
		{cs_ale_mode_i, cs_dir_strobe_mode_i} = '0;
		cs_ready_en_i = 5'h04;
		cs_bus16_i = 5'h0E;
		{dly, mute, seen5, seenf, seenr, wm} = '0;
		for (k = 0; k < 32768; k++) sh[k] = 8'h00;
		rst_n_i = 1'b0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		// random traffic over an 8-bit, a 16-bit and a ready-ended select
		for (i = 0; i < 40; i++) begin
			rnd = lfsr(rnd);
			sz = (rnd[3:2] == 2'h3) ? 3'h2 : {1'b0, rnd[3:2]};
			a = (28'(rnd[1:0] == 2'h3 ? 2'h2 : rnd[1:0]) << 12) |
				28'(rnd[15:6] & ~((10'h1 << sz) - 10'h1));
			w = rnd[4];
			dly <= {1'b0, rnd[7:5]} + 4'h1;
			rnd = lfsr(rnd);
			acc(w, a, sz, {rnd, ~rnd});
			`CHK(er, 1'b0)
		end
		`CHK(seenr, 1'b1)
		mute <= 1'b1;
		acc(1'b1, 28'h2FF0, 3'h1, 32'h0000A5C3);
		`CHK(er, 1'b1)
		mute <= 1'b0;
		acc(1'b0, 28'h5000, 3'h2, '0);
		`CHK(er, 1'b1)
		// normal, latch, direction-strobe and both on one select
		for (m = 0; m < 4; m++) begin
			cs_ale_mode_i[3] <= m[0];
			cs_dir_strobe_mode_i[3] <= 1'b0;
			@(posedge clk_i);
			rnd = lfsr(rnd);
			acc(1'b1, 28'h3000 + 28'(8 * m), 3'h2, {~rnd, rnd});
			cs_dir_strobe_mode_i[3] <= m[1];
			seena = 1'b0;
			@(posedge clk_i);
			acc(1'b0, 28'h3000 + 28'(8 * m), 3'h2, '0);
			`CHK(seena, m == 1)
		end
		cs_ale_mode_i[3] <= 1'b0;
		cs_dir_strobe_mode_i[3] <= 1'b0;
		{seen5, seenf} = 2'h0;
		acc(1'b1, 28'h4400, 3'h0, 32'h00000070);
		acc(1'b1, 28'h4201, 3'h0, 32'h00001100);
		`CHK({seen5, seenf}, 2'h3)
		nand_mode_i <= 1'b0;
		fifth_select_enable_i <= 1'b1;
		@(posedge clk_i);
		{seen5, seenf} = 2'h0;
		acc(1'b1, 28'h4010, 3'h0, 32'h0);
		`CHK({seen5, seenf}, 2'h2)
		// divider clamp and range, then the output gate
		for (i = 0; i < 3; i++) begin
			clk_div_i <= (i == 0) ? 4'h2 : (i == 1) ? 4'h3 : 4'hF;
			repeat (40) @(posedge clk_i);
			k = rises;
			repeat (30 * ((i == 2) ? 15 : 3)) @(posedge clk_i);
			`CHK(rises - k, 30)
		end
		clk_out_en_i <= 1'b0;
		repeat (20) @(posedge clk_i);
		k = rises;
		repeat (60) @(posedge clk_i);
		`CHK(rises - k, 0)
		`CHK(exp_clk_oe_o, 1'b0)
		give_verdict();
	end
endmodule : expansion_bus_cycle_engine_bench
`default_nettype wire
